// [src/pbs_pkg.sv]
// Shared constants and types for the pipelined burst memory port
package pbs_pkg;

    // Geometry of the wide configuration: two lanes of two bytes plus parity each
    localparam int unsigned LANE_W     = 18;
    localparam int unsigned DATA_W     = 2 * LANE_W;
    localparam int unsigned BURST_W    = 2;
    localparam int unsigned UPPER_W    = 18;
    localparam int unsigned ADDR_W     = UPPER_W + BURST_W;
    localparam int unsigned MEM_WORDS  = 1 << ADDR_W;
    localparam int unsigned LANES      = 2;

    // Read data buffer in front of the output register
    localparam int unsigned FIFO_DEPTH = 32;

    // Lane positions inside a stored word
    localparam int unsigned LOWER_LSB  = 0;
    localparam int unsigned UPPER_LSB  = LANE_W;

    // Lane-enable bit positions
    localparam int unsigned SEL_LOWER  = 0;
    localparam int unsigned SEL_UPPER  = 1;

    // Wide configuration honours the lane selects; narrow writes every lane
    localparam logic        WIDE_CONFIG   = 1'b1;
    localparam logic [1:0]  ALL_LANES     = 2'h3;

    // Burst beat step and start
    localparam logic [1:0]  BEAT_FIRST    = 2'h0;
    localparam logic [1:0]  BEAT_STEP     = 2'h1;

    // Sleep entry and exit each take this many clock cycles
    localparam int unsigned SLEEP_CYCLES  = 2;

    // Gray-coded sleep sequence: awake, entering, asleep, leaving
    typedef enum logic [1:0] {
        SLP_AWAKE  = 2'h0,
        SLP_ENTER  = 2'h1,
        SLP_ASLEEP = 2'h3,
        SLP_EXIT   = 2'h2
    } pbs_sleep_t;

    localparam pbs_sleep_t SLEEP_RST = SLP_AWAKE;

endpackage : pbs_pkg

// [src/pbs_fifo.sv]
// Parameterised first-word-fall-through FIFO with valid/ready on both sides
module pbs_fifo #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = PTR_W + 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wr_ptr;
        logic [PTR_W-1:0]            rd_ptr;
        logic [CNT_W-1:0]            count;
    } pbs_fifo_state_t;

    pbs_fifo_state_t r;
    pbs_fifo_state_t next_r;
    logic            push;
    logic            pop;

    assign in_ready_o  = (r.count != CNT_W'(DEPTH));
    assign out_valid_o = (r.count != '0);
    assign out_data_o  = r.mem[r.rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;

    always_comb
    begin
        next_r = r;
        if (push)
        begin
            next_r.mem[r.wr_ptr] = in_data_i;
            next_r.wr_ptr        = (r.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(r.wr_ptr + 1'b1);
        end
        if (pop)
        begin
            next_r.rd_ptr = (r.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(r.rd_ptr + 1'b1);
        end
        case ({push, pop})
            2'b10:   next_r.count = CNT_W'(r.count + 1'b1);
            2'b01:   next_r.count = CNT_W'(r.count - 1'b1);
            default: next_r.count = r.count;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            r.wr_ptr <= '0;
            r.rd_ptr <= '0;
            r.count  <= '0;
            r.mem    <= next_r.mem;
        end
        else
        begin
            r <= next_r;
        end
    end

endmodule // pbs_fifo

// [src/pbs_port.sv]
// Pipelined burst memory port: command pipeline, burst counter, array and output stage
//
// Overview of operation
// - Capture inputs only on qualified rising edges
// - Clock enable high holds internal state except sleep and drive gate
// - Select needs all three enables active
// - Read starts on load, selected, write high
// - Read data leaves output register next edge
// - Back-to-back commands accepted without idle cycles
// - Deselect floats outputs after the next edge
// - Output drive low gates outputs, writes mask
// - Write data sampled into input registers
// - Wide config lane selects gate each lane
// - Write starts on load, selected, write low
// - Load low takes new address, new burst
// - Up to four beats from one address
// - Order strap: low linear, high interleaved
// - Counter uses two low bits, wraps
// - Advance ignores chip enables and write enable
// - Burst keeps direction captured at first beat
// - Sleep input high puts device asleep
// - Linear order counts up modulo four
// - Interleaved order XORs start with beat
// - Write data taken two edges after command
// - Sleep entry/exit two cycles, pending dropped
module pbs_port
    import pbs_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       clk_qualify_low_i,
    input  wire logic                       chip_sel_first_low_i,
    input  wire logic                       chip_sel_second_high_i,
    input  wire logic                       chip_sel_third_low_i,
    input  wire logic [pbs_pkg::UPPER_W-1:0] addr_upper_i,
    input  wire logic                       burst_addr_bit1_i,
    input  wire logic                       burst_addr_bit0_i,
    input  wire logic                       write_en_low_i,
    input  wire logic                       advance_or_load_i,
    input  wire logic                       byte_sel_upper_low_i,
    input  wire logic                       byte_sel_lower_low_i,
    input  wire logic                       burst_order_i,
    input  wire logic                       output_drive_low_i,
    input  wire logic                       sleep_request_i,
    input  wire logic [pbs_pkg::LANE_W-1:0]  data_lane_lower_i,
    input  wire logic [pbs_pkg::LANE_W-1:0]  data_lane_upper_i,
    output logic      [pbs_pkg::LANE_W-1:0]  data_lane_lower_o,
    output logic      [pbs_pkg::LANE_W-1:0]  data_lane_upper_o,
    output logic                            data_drive_o,
    output logic                            sleep_active_o
);

    import pbs_pkg::*;

    typedef struct packed {
        pbs_sleep_t          slp;
        logic                asleep;
        logic                burst_on;
        logic                burst_wr;
        logic [UPPER_W-1:0]  base;
        logic [BURST_W-1:0]  start;
        logic [BURST_W-1:0]  beat;
        logic                s1_valid;
        logic                s1_wr;
        logic [ADDR_W-1:0]   s1_addr;
        logic [LANES-1:0]    s1_sel;
        logic                s2_valid;
        logic                s2_wr;
        logic [ADDR_W-1:0]   s2_addr;
        logic [LANES-1:0]    s2_sel;
        logic [DATA_W-1:0]   out_data;
        logic                out_on;
        logic                drive;
    } pbs_port_state_t;

    localparam pbs_port_state_t STATE_RST = '{
        slp:      SLEEP_RST,
        default:  '0
    };

    // Next two burst address bits for a given beat in the selected order
    function automatic logic [BURST_W-1:0] burst_bits(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] beat,
        input logic               interleaved
    );
        if (interleaved)
        begin
            burst_bits = start ^ beat;
        end
        else
        begin
            burst_bits = BURST_W'(start + beat);
        end
    endfunction

    // Replace only the enabled lanes of a stored word
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [LANES-1:0]  sel
    );
        lane_merge = old_word;
        if (sel[SEL_LOWER])
        begin
            lane_merge[LOWER_LSB +: LANE_W] = new_word[LOWER_LSB +: LANE_W];
        end
        if (sel[SEL_UPPER])
        begin
            lane_merge[UPPER_LSB +: LANE_W] = new_word[UPPER_LSB +: LANE_W];
        end
    endfunction

    pbs_port_state_t     r;
    pbs_port_state_t     next_r;

    logic [DATA_W-1:0]   mem [MEM_WORDS];

    logic                qualified;
    logic                awake;
    logic                selected;
    logic                cur_valid;
    logic                cur_wr;
    logic [ADDR_W-1:0]   cur_addr;
    logic [LANES-1:0]    cur_sel;
    logic                mem_we;
    logic [DATA_W-1:0]   wr_data;
    logic [DATA_W-1:0]   rd_word;
    logic                fifo_in_valid;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_ready;
    logic [DATA_W-1:0]   fifo_out_data;
    logic [BURST_W-1:0]  beat_inc;

    // A full read buffer stalls the port like a masked clock, so no read is lost
    assign qualified = ~clk_qualify_low_i & fifo_in_ready;
    assign awake     = (r.slp == SLP_AWAKE);
    assign selected  = ~chip_sel_first_low_i & chip_sel_second_high_i & ~chip_sel_third_low_i;
    assign beat_inc  = BURST_W'(r.beat + BEAT_STEP);

    // Decode of the beat presented at this edge
    always_comb
    begin
        cur_valid = 1'b0;
        cur_wr    = 1'b0;
        cur_addr  = {addr_upper_i, burst_addr_bit1_i, burst_addr_bit0_i};
        // Lane selects are taken with every beat, first or continued
        cur_sel   = WIDE_CONFIG ? ~{byte_sel_upper_low_i, byte_sel_lower_low_i} : ALL_LANES;
        if (awake)
        begin
            if (!advance_or_load_i)
            begin
                cur_valid = selected;
                cur_wr    = ~write_en_low_i;
            end
            else if (r.burst_on)
            begin
                // Enables and write enable are not looked at while advancing
                cur_valid = 1'b1;
                cur_wr    = r.burst_wr;
                cur_addr  = {r.base, burst_bits(r.start, beat_inc, burst_order_i)};
            end
        end
    end

    // Write data arrives two edges after its command and is merged per lane
    assign wr_data = {data_lane_upper_i, data_lane_lower_i};
    assign mem_we  = qualified & awake & r.s2_valid & r.s2_wr & ~srst_i;

    // Forward a write landing at the same edge so a following read sees it
    always_comb
    begin
        rd_word = mem[cur_addr];
        if (mem_we && (r.s2_addr == cur_addr))
        begin
            rd_word = lane_merge(rd_word, wr_data, r.s2_sel);
        end
    end

    assign fifo_in_valid  = ~clk_qualify_low_i & cur_valid & ~cur_wr;
    // Asleep, whatever was buffered for a dropped read is drained away
    assign fifo_out_ready = (qualified & r.s1_valid & ~r.s1_wr) | r.asleep;

    pbs_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rd_fifo (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .in_valid_i  (fifo_in_valid),
        .in_data_i   (rd_word),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_out_ready)
    );

    always_comb
    begin
        next_r = r;

        // Sleep runs whatever the clock enable says
        unique case (r.slp)
            SLP_AWAKE:
            begin
                if (sleep_request_i)
                begin
                    next_r.slp = SLP_ENTER;
                end
            end
            SLP_ENTER:
            begin
                next_r.slp = sleep_request_i ? SLP_ASLEEP : SLP_AWAKE;
            end
            SLP_ASLEEP:
            begin
                if (!sleep_request_i)
                begin
                    next_r.slp = SLP_EXIT;
                end
            end
            SLP_EXIT:
            begin
                next_r.slp = sleep_request_i ? SLP_ASLEEP : SLP_AWAKE;
            end
        endcase

        if (qualified && awake)
        begin
            // Burst bookkeeping
            if (!advance_or_load_i)
            begin
                next_r.burst_on = selected;
                next_r.burst_wr = ~write_en_low_i;
                next_r.base     = addr_upper_i;
                next_r.start    = {burst_addr_bit1_i, burst_addr_bit0_i};
                next_r.beat     = BEAT_FIRST;
            end
            else if (r.burst_on)
            begin
                next_r.beat = beat_inc;
            end

            // Command pipeline: every edge takes a new beat or a deselect
            next_r.s1_valid = cur_valid;
            next_r.s1_wr    = cur_wr;
            next_r.s1_addr  = cur_addr;
            next_r.s1_sel   = cur_sel;
            next_r.s2_valid = r.s1_valid;
            next_r.s2_wr    = r.s1_wr;
            next_r.s2_addr  = r.s1_addr;
            next_r.s2_sel   = r.s1_sel;

            // Output stage: read data one edge after its command, else float
            next_r.out_on = r.s1_valid & ~r.s1_wr;
            if (r.s1_valid && !r.s1_wr && fifo_out_valid)
            begin
                next_r.out_data = fifo_out_data;
            end
        end

        // Pending work is abandoned once asleep; stored words are kept
        if (next_r.slp == SLP_ASLEEP)
        begin
            next_r.burst_on = 1'b0;
            next_r.s1_valid = 1'b0;
            next_r.s2_valid = 1'b0;
            next_r.out_on   = 1'b0;
        end
        // Still reported asleep while leaving, so the flag drops only after two low edges
        next_r.asleep = (next_r.slp == SLP_ASLEEP) || (next_r.slp == SLP_EXIT);

        // Drive gate is resampled every edge, so a stall keeps the data but not the gate
        next_r.drive = next_r.out_on & ~output_drive_low_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            r <= STATE_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Array write port; the array itself is never reset
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
        begin
            mem[r.s2_addr] <= lane_merge(mem[r.s2_addr], wr_data, r.s2_sel);
        end
    end

    assign data_lane_lower_o = r.out_data[LOWER_LSB +: LANE_W];
    assign data_lane_upper_o = r.out_data[UPPER_LSB +: LANE_W];
    assign data_drive_o      = r.drive;
    assign sleep_active_o    = r.asleep;

endmodule // pbs_port

// [dv/pbs_port_sva.sv]
// Concurrent checks on the pins of the pipelined burst memory port
module pbs_port_sva
    import pbs_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               srst_i,
    input wire logic               clk_qualify_low_i,
    input wire logic               chip_sel_first_low_i,
    input wire logic               chip_sel_second_high_i,
    input wire logic               chip_sel_third_low_i,
    input wire logic               write_en_low_i,
    input wire logic               advance_or_load_i,
    input wire logic               output_drive_low_i,
    input wire logic               sleep_request_i,
    input wire logic  [LANE_W-1:0] data_lane_lower_o,
    input wire logic  [LANE_W-1:0] data_lane_upper_o,
    input wire logic               data_drive_o,
    input wire logic               sleep_active_o
);
    logic prev_slp;
    logic awake, cmd, sel, rd, wr, desel;
    always_ff @(posedge clk_i)
    begin
        prev_slp <= sleep_request_i;
    end
    // Commands count only in a settled awake state, never during entry or exit
    assign awake = !sleep_active_o && !sleep_request_i && !prev_slp;
    assign cmd   = !clk_qualify_low_i && awake;
    assign sel   = !chip_sel_first_low_i && chip_sel_second_high_i && !chip_sel_third_low_i;
    assign rd    = cmd && !advance_or_load_i && sel && write_en_low_i;
    assign wr    = cmd && !advance_or_load_i && sel && !write_en_low_i;
    assign desel = cmd && !advance_or_load_i && !sel;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_read_drive: assert property (rd ##1 (cmd && !output_drive_low_i) |=> data_drive_o)
        else $error("read beat did not drive the bus");
    a_write_float: assert property (wr ##1 cmd |=> !data_drive_o)
        else $error("bus driven in write data slot");
    a_desel_float: assert property (desel ##1 cmd |=> !data_drive_o)
        else $error("bus driven after deselect");
    a_adv_idle: assert property (desel ##1 (cmd && advance_or_load_i) ##1 cmd |=> !data_drive_o)
        else $error("advance without burst drove the bus");
    a_oe_float: assert property (output_drive_low_i |=> !data_drive_o)
        else $error("bus driven with output enable high");
    a_stall_hold: assert property (clk_qualify_low_i && awake |=> $stable({data_lane_upper_o, data_lane_lower_o}))
        else $error("read data moved during stall");
    a_sleep_in: assert property (sleep_request_i [*2] |=> sleep_active_o)
        else $error("sleep not entered after two edges");
    a_sleep_out: assert property (!sleep_request_i [*2] |=> !sleep_active_o)
        else $error("sleep not left after two edges");
    a_sleep_quiet: assert property (sleep_active_o |-> !data_drive_o)
        else $error("bus driven while asleep");
    cover property (rd ##1 rd);
    cover property (wr ##1 rd);
    cover property (cmd && advance_or_load_i ##1 clk_qualify_low_i);
    cover property (sleep_active_o);
endmodule // pbs_port_sva

bind pbs_port pbs_port_sva u_pbs_sva (.*);

// [dv/pbs_ctrl_model.sv]
// Controller data side: drives write data two edges after each write beat
module pbs_ctrl_model
    import pbs_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    input  wire logic              clk_qualify_low_i,
    input  wire logic              wr_beat_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W:0]   s0, s1;
    logic [DATA_W-1:0] last;
    // Released bus shows the inverse of its last value so stale data never looks valid
    assign wdata_o = s1[DATA_W] ? s1[DATA_W-1:0] : ~last;
    always_ff @(posedge clk_i)
    begin
        last <= srst_i ? '0 : wdata_o;
        if (srst_i)
        begin
            s0 <= '0;
            s1 <= '0;
        end
        else if (!clk_qualify_low_i)
        begin
            s0 <= {wr_beat_i, wdata_i};
            s1 <= s0;
        end
    end
endmodule // pbs_ctrl_model

// [dv/pbs_port_tb.sv]
// Self-checking bench for the pipelined burst memory port
module pbs_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pbs_pkg::*;
    logic clk_i = 0, srst_i = 1, clk_qualify_low_i = 0, write_en_low_i = 1, advance_or_load_i = 0;
    logic chip_sel_first_low_i = 1, chip_sel_second_high_i = 0, chip_sel_third_low_i = 0;
    logic burst_addr_bit1_i = 0, burst_addr_bit0_i = 0, byte_sel_upper_low_i = 0, byte_sel_lower_low_i = 0;
    logic burst_order_i = 1, output_drive_low_i = 0, sleep_request_i = 0, wr_beat = 0;
    logic [UPPER_W-1:0] addr_upper_i = '0;
    logic [DATA_W-1:0]  wdata = '0, ctl_bus, d;
    wire logic [LANE_W-1:0] data_lane_lower_i, data_lane_upper_i;
    logic [LANE_W-1:0] data_lane_lower_o, data_lane_upper_o;
    logic        data_drive_o, sleep_active_o, bst_on, bst_wr, oe_cur, slp_cur, exp_sa, last_rd, prev_stall;
    logic [19:0] bst_a, grp[$];
    logic [1:0]  bst_n, h;
    logic        q_rd[$];
    logic [35:0] q_d[$];
    logic [35:0] mem [logic [19:0]];
    logic [31:0] seed = 32'h3d;
    int          err_count = 0, num_checks = 0;
    assign {data_lane_upper_i, data_lane_lower_i} = data_drive_o ? {data_lane_upper_o, data_lane_lower_o} : ctl_bus;
    pbs_port DUT (.*);
    pbs_ctrl_model u_ctl (.clk_i(clk_i), .srst_i(srst_i), .clk_qualify_low_i(clk_qualify_low_i),
                          .wr_beat_i(wr_beat), .wdata_i(wdata), .wdata_o(ctl_bus));
    always #20 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] beat_lo(input logic [1:0] s, input logic [1:0] n, input logic ord);
        return ord ? s ^ n : s + n;
    endfunction
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // op: 0 deselect, 1 read, 2 write, 3 advance, 4 stall
    task automatic cyc(input int op, input logic [19:0] a, input logic [1:0] bs, input logic oe, input logic slp);
        logic [19:0] ba;
        logic [2:0]  v;
        logic        rd, old_oe, ign, wb;
        @(posedge clk_i);
        h = {h[0], slp_cur};
        if (h == 2'b11) exp_sa = 1;
        else if (h == 2'b00) exp_sa = 0;
        old_oe = oe_cur;
        ign = exp_sa || slp;
        d = 36'(rnd()) ^ (36'(rnd()) << 4);
        v = 3'(rnd());
        if (op == 0 && v == 3'b010) v = 3'b110;
        if (op == 1 || op == 2) v = 3'b010;
        {chip_sel_first_low_i, chip_sel_second_high_i, chip_sel_third_low_i} <= v;
        clk_qualify_low_i <= (op == 4);
        advance_or_load_i <= (op == 3);
        write_en_low_i <= op == 2 ? 1'b0 : op == 1 ? 1'b1 : 1'(rnd());
        {addr_upper_i, burst_addr_bit1_i, burst_addr_bit0_i} <= op == 3 ? 20'(rnd()) : a;
        {byte_sel_upper_low_i, byte_sel_lower_low_i} <= bs;
        output_drive_low_i <= oe;
        sleep_request_i <= slp;
        oe_cur = oe;
        slp_cur = slp;
        rd = 0;
        wb = 0;
        wdata <= d;
        if (op != 4)
        begin
            if (ign || op == 0) bst_on = 0;
            else if (op != 3 || bst_on)
            begin
                if (op != 3)
                begin
                    bst_on = 1;
                    bst_wr = (op == 2);
                    bst_a = a;
                    bst_n = 0;
                end
                else bst_n++;
                ba = {bst_a[19:2], beat_lo(bst_a[1:0], bst_n, burst_order_i)};
                if (bst_wr)
                begin
                    wb = 1;
                    if (!bs[0]) mem[ba][17:0] = d[17:0];
                    if (!bs[1]) mem[ba][35:18] = d[35:18];
                end
                else
                begin
                    rd = 1;
                    d = mem[ba];
                end
            end
            q_rd.push_back(rd);
            q_d.push_back(d);
        end
        wr_beat <= wb;
        @(negedge clk_i);
        chk(36'(sleep_active_o), 36'(exp_sa));
        if (!prev_stall)
        begin
            last_rd = q_rd.pop_front();
            d = q_d.pop_front();
            if (last_rd && !old_oe) chk({data_lane_upper_o, data_lane_lower_o}, d);
        end
        chk(36'(data_drive_o), 36'(last_rd && !old_oe));
        prev_stall = (op == 4);
    endtask
    task automatic rburst(input int op, input logic [19:0] a, input int n, input logic oe);
        cyc(op, a, 2'b00, oe, 0);
        repeat (n - 1)
        begin
            if (rnd() % 5 == 0) cyc(4, 0, 0, 1'(rnd()), 0);
            cyc(3, 0, 2'b00, oe, 0);
        end
    endtask
    initial
    begin
        h = 0; exp_sa = 0; oe_cur = 0; slp_cur = 0; prev_stall = 0; last_rd = 0; bst_on = 0;
        q_rd = '{1'b0, 1'b0};
        q_d = '{36'h0, 36'h0};
        repeat (10) @(posedge clk_i);
        srst_i <= 0;
        @(negedge clk_i);
        chk({data_lane_upper_o, data_lane_lower_o}, 36'h0);
        chk(36'({data_drive_o, sleep_active_o}), 36'h0);
        for (int i = 0; i < 8; i++)
        begin
            // Strap moves after the last beat's edge and before the deselect edge, so no open burst sees the change
            cyc(0, 0, 0, 0, 0);
            burst_order_i <= i[2];
            bst_a = {18'(rnd()), i[1:0]};
            grp.push_back(bst_a);
            rburst(2, bst_a, 5, 0);
            cyc(0, 0, 0, 0, 0);
            rburst(1, grp[i], 4, 0);
        end
        cyc(2, grp[0], 2'b10, 0, 0);
        cyc(2, grp[1], 2'b01, 0, 0);
        cyc(0, 0, 0, 0, 0);
        cyc(1, grp[0], 0, 0, 0);
        cyc(1, grp[1], 0, 0, 0);
        cyc(0, 0, 0, 0, 0);
        cyc(3, 0, 0, 0, 0);
        cyc(3, 0, 0, 0, 0);
        for (int i = 0; i < 9; i++) cyc(i == 4 ? 1 : 0, grp[2], 0, 0, i > 1 && i < 6);
        for (int i = 0; i < 24; i++)
        begin
            bst_a = {18'(rnd()), 2'b00};
            grp.push_back(bst_a);
            rburst(2, bst_a, 4, 0);
            cyc(0, 0, 0, 0, 0);
            rburst(1, grp[rnd() % grp.size()] ^ 20'(rnd() % 4), 1 + rnd() % 4, rnd() % 6 == 0);
        end
        cyc(0, 0, 0, 0, 0);
        cyc(0, 0, 0, 0, 0);
        results();
    end
    initial
    begin
        repeat (8000) @(posedge clk_i);
        err_count++;
        results();
    end
endmodule // pbs_port_tb
